// [rtl/mcr_map.svh]
// Register offsets, field positions and reset values of the collision block
`ifndef MCR_MAP_SVH
`define MCR_MAP_SVH

`define MCR_ADDR_W         8
`define MCR_OFS_CFG        8'h00
`define MCR_OFS_CFG_CLR    8'h04
`define MCR_OFS_CFG_SET    8'h08
`define MCR_OFS_CFG_INV    8'h0C
`define MCR_OFS_STAT       8'h10
`define MCR_OFS_MASK       8'h14

`define MCR_SLOT_LSB       8
`define MCR_SLOT_MSB       13
`define MCR_RETRY_LSB      0
`define MCR_RETRY_MSB      3
`define MCR_CFG_IMPL       32'h00003F0F
`define MCR_CFG_RST        32'h0000370F

`define MCR_ST_EXCESS      0
`define MCR_ST_LATE        1
`define MCR_ST_RETRY       2
`define MCR_ST_IMPL        32'h00000007
`define MCR_ST_ATT_LSB     8
`define MCR_ST_ATT_MSB     11
`define MCR_MASK_RST       32'h00000000

`endif

// [rtl/mcr_pkg.sv]
// Types shared by the collision window and retry limit block
package mcr_pkg;

	typedef enum logic [2:0] {
		MCR_IDLE = 3'b001,
		MCR_SEND = 3'b010,
		MCR_HOLD = 3'b100
	} mcr_state_t;

	typedef struct packed {
		logic start;
		logic byte_sent;
		logic done;
	} mcr_tx_evt_t;

	typedef struct packed {
		logic retry;
		logic abort;
		logic late;
	} mcr_tx_ans_t;

endpackage

// [rtl/mcr_collision_retry.sv]
// Collision window and retry limit register with transmit retry logic
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.svh"

module mcr_collision_retry (
	input  wire logic                 clock_i,
	input  wire logic                 rst_b_i,
	input  wire logic [7:0]           avs_address_i,
	input  wire logic                 avs_read_i,
	input  wire logic                 avs_write_i,
	input  wire logic [3:0]           avs_byteenable_i,
	input  wire logic [31:0]          avs_writedata_i,
	output var  logic [31:0]          avs_readdata_o,
	output logic                      avs_waitrequest_o,
	input  wire mcr_pkg::mcr_tx_evt_t tx_evt_i,
	input  wire logic                 collision_i,
	output var  mcr_pkg::mcr_tx_ans_t tx_ans_o,
	output logic                      irq_o
);
	import mcr_pkg::*;

	// Legal transfer: full word or either aligned half word
	function automatic logic lanes_ok(input logic [3:0] be);
		lanes_ok = (be == 4'hF) || (be == 4'h3) || (be == 4'hC);
	endfunction

	logic [31:0] cfg_q, cfg_d;
	logic [31:0] stat_q, stat_d;
	logic [31:0] mask_q, mask_d;
	logic [31:0] rdata_d;
	logic        ack_q;
	logic [31:0] lane_mask;
	logic [2:0]  col_sync_q;
	mcr_state_t  state_q, state_d;
	logic [6:0]  byte_cnt_q, byte_cnt_d;
	logic [3:0]  attempt_q, attempt_d;
	mcr_tx_ans_t ans_d;

	// Byte lanes expanded to a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign lane_mask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
		end
	endgenerate

	// Bus decode; one wait cycle, then the request completes
	wire req      = avs_read_i | avs_write_i;
	wire legal    = lanes_ok(avs_byteenable_i);
	wire wr_take  = avs_write_i & ack_q & legal;
	wire rd_take  = avs_read_i & legal;
	wire wr_cfg   = wr_take && (avs_address_i == `MCR_OFS_CFG);
	wire wr_clr   = wr_take && (avs_address_i == `MCR_OFS_CFG_CLR);
	wire wr_set   = wr_take && (avs_address_i == `MCR_OFS_CFG_SET);
	wire wr_inv   = wr_take && (avs_address_i == `MCR_OFS_CFG_INV);
	wire wr_stat  = wr_take && (avs_address_i == `MCR_OFS_STAT);
	wire wr_mask  = wr_take && (avs_address_i == `MCR_OFS_MASK);
	wire [31:0] wmask = lane_mask & avs_writedata_i;
	assign avs_waitrequest_o = req & ~ack_q;

	// Config field views
	wire [5:0] slot_window_bytes  = cfg_q[`MCR_SLOT_MSB:`MCR_SLOT_LSB];
	wire [3:0] max_retry_attempts = cfg_q[`MCR_RETRY_MSB:`MCR_RETRY_LSB];

	// Config register with clear, set and invert aliases
	always_comb begin
		cfg_d = cfg_q;
		if (wr_cfg)
			cfg_d = (cfg_q & ~lane_mask) | wmask;
		else if (wr_clr)
			cfg_d = cfg_q & ~wmask;
		else if (wr_set)
			cfg_d = cfg_q | wmask;
		else if (wr_inv)
			cfg_d = cfg_q ^ wmask;
		cfg_d = cfg_d & `MCR_CFG_IMPL;
	end

	// Status: hardware set beats a write-one clear
	always_comb begin
		stat_d = stat_q;
		if (wr_stat)
			stat_d = stat_q & ~wmask;
		stat_d[`MCR_ST_EXCESS] = stat_d[`MCR_ST_EXCESS] | ans_d.abort;
		stat_d[`MCR_ST_LATE]   = stat_d[`MCR_ST_LATE] | ans_d.late;
		stat_d[`MCR_ST_RETRY]  = stat_d[`MCR_ST_RETRY] | ans_d.retry;
		stat_d = stat_d & `MCR_ST_IMPL;
		mask_d = mask_q;
		if (wr_mask)
			mask_d = ((mask_q & ~lane_mask) | wmask) & `MCR_ST_IMPL;
	end

	// Read mux; illegal widths and holes read zero
	always_comb begin
		rdata_d = 32'h00000000;
		if (rd_take) begin
			case (avs_address_i)
				`MCR_OFS_CFG, `MCR_OFS_CFG_CLR,
				`MCR_OFS_CFG_SET, `MCR_OFS_CFG_INV:
					rdata_d = cfg_q & `MCR_CFG_IMPL;
				`MCR_OFS_STAT: begin
					rdata_d = stat_q;
					rdata_d[`MCR_ST_ATT_MSB:`MCR_ST_ATT_LSB] = attempt_q;
				end
				`MCR_OFS_MASK:
					rdata_d = mask_q;
				default:
					rdata_d = 32'h00000000;
			endcase
		end
	end

	// Bus registers
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_q          <= 1'b0;
			avs_readdata_o <= 32'h00000000;
			cfg_q          <= `MCR_CFG_RST;
			stat_q         <= 32'h00000000;
			mask_q         <= `MCR_MASK_RST;
			irq_o          <= 1'b0;
		end else begin
			ack_q          <= req & ~ack_q;
			avs_readdata_o <= rdata_d;
			cfg_q          <= cfg_d;
			stat_q         <= stat_d;
			mask_q         <= mask_d;
			irq_o          <= |(stat_d & mask_d);
		end
	end

	// Collision pin synchroniser plus edge history
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i)
			col_sync_q <= 3'b000;
		else
			col_sync_q <= {col_sync_q[1:0], collision_i};
	end
	wire col_rise = col_sync_q[1] & ~col_sync_q[2];

	// Window test: bytes counted so far include preamble and SFD
	wire [6:0] bytes_now = byte_cnt_q + {6'h00, tx_evt_i.byte_sent};
	wire in_window = bytes_now <= {1'b0, slot_window_bytes};
	wire limit_hit = attempt_q >= max_retry_attempts;

	// Transmit attempt state machine
	always_comb begin
		state_d    = state_q;
		byte_cnt_d = byte_cnt_q;
		attempt_d  = attempt_q;
		ans_d      = '0;
		case (state_q)
			MCR_IDLE, MCR_HOLD: begin
				if (tx_evt_i.start) begin
					state_d    = MCR_SEND;
					byte_cnt_d = {6'h00, tx_evt_i.byte_sent};
				end
			end
			MCR_SEND: begin
				if (!byte_cnt_q[6])
					byte_cnt_d = bytes_now;
				if (col_rise && in_window) begin
					if (limit_hit) begin
						ans_d.abort = 1'b1;
						attempt_d   = 4'h0;
						state_d     = MCR_IDLE;
					end else begin
						ans_d.retry = 1'b1;
						attempt_d   = attempt_q + 4'h1;
						state_d     = MCR_HOLD;
					end
				end else if (col_rise) begin
					ans_d.late = 1'b1;
					attempt_d  = 4'h0;
					state_d    = MCR_IDLE;
				end else if (tx_evt_i.done) begin
					attempt_d = 4'h0;
					state_d   = MCR_IDLE;
				end
			end
			default:
				state_d = MCR_IDLE;
		endcase
	end

	// Transmit state registers
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q    <= MCR_IDLE;
			byte_cnt_q <= 7'h00;
			attempt_q  <= 4'h0;
			tx_ans_o   <= '0;
		end else begin
			state_q    <= state_d;
			byte_cnt_q <= byte_cnt_d;
			attempt_q  <= attempt_d;
			tx_ans_o   <= ans_d;
		end
	end

	// Checks
	AST_SLOT_RESET: assert property (@(posedge clock_i)
		$rose(rst_b_i) |-> slot_window_bytes == 6'h37)
		else $error("slot window not 0x37 after reset");

	AST_WINDOW_FROM_FIRST: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(state_q != MCR_SEND && tx_evt_i.start && tx_evt_i.byte_sent)
		|=> byte_cnt_q == 7'h01)
		else $error("first byte not counted in window");

	AST_RETRY_COUNT: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(state_q == MCR_SEND && col_rise && in_window && !limit_hit)
		|=> tx_ans_o.retry && attempt_q == $past(attempt_q) + 4'h1)
		else $error("retry not issued or not counted");

	AST_ABORT_AT_LIMIT: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		tx_ans_o.abort |-> $past(attempt_q) >= $past(max_retry_attempts))
		else $error("abort before retry limit");

	AST_BYTE_IGNORED: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(avs_write_i && !lanes_ok(avs_byteenable_i)) |=> $stable(cfg_q))
		else $error("8-bit write changed config");

	AST_RESERVED_ZERO: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(avs_read_i && !avs_waitrequest_o && avs_address_i == `MCR_OFS_CFG)
		|-> (avs_readdata_o & ~`MCR_CFG_IMPL) == 32'h00000000)
		else $error("reserved config bits read nonzero");

	AST_EXCESS_FLAG: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		tx_ans_o.abort |-> stat_q[`MCR_ST_EXCESS] ##1 stat_q[`MCR_ST_EXCESS])
		else $error("excessive collision flag not set");

	AST_IRQ_LEVEL: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		##1 irq_o == |(stat_q & mask_q))
		else $error("interrupt does not follow masked status");

	// Reset, transmit, status and bus checks
	AST_RETRY_RESET: assert property (@(posedge clock_i)
		$rose(rst_b_i) |-> max_retry_attempts == 4'hF)
		else $error("retry limit not 0xF after reset");

	AST_LATE_NO_RETRY: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(state_q == MCR_SEND && col_rise && !in_window)
		|=> tx_ans_o.late && !tx_ans_o.retry && attempt_q == 4'h0)
		else $error("collision past window handled as in-window");

	AST_ABORT_CLEARS: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		tx_ans_o.abort |-> attempt_q == 4'h0 && state_q == MCR_IDLE)
		else $error("attempt count kept after abort");

	AST_COUNT_SATURATES: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(state_q == MCR_SEND && byte_cnt_q[6]) |=> byte_cnt_q == 7'h40)
		else $error("window byte count wrapped");

	AST_EXCESS_STICKY: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(stat_q[`MCR_ST_EXCESS] && !(wr_stat && wmask[`MCR_ST_EXCESS]))
		|=> stat_q[`MCR_ST_EXCESS])
		else $error("excessive collision flag lost without clear");

	AST_NARROW_READ_ZERO: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(avs_read_i && !avs_waitrequest_o && !lanes_ok(avs_byteenable_i))
		|-> avs_readdata_o == 32'h00000000)
		else $error("8-bit read returned data");

	AST_WAIT_ONE: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(avs_waitrequest_o && req) |=> !avs_waitrequest_o)
		else $error("more than one wait cycle");

	AST_QUIET_OUTSIDE_SEND: assert property (@(posedge clock_i)
		disable iff (!rst_b_i)
		(state_q != MCR_SEND) |=> tx_ans_o == '0)
		else $error("answer pulse outside a send");

	COV_RETRY: cover property (@(posedge clock_i) disable iff (!rst_b_i)
		tx_ans_o.retry);
	COV_ABORT: cover property (@(posedge clock_i) disable iff (!rst_b_i)
		tx_ans_o.abort);
	COV_LATE: cover property (@(posedge clock_i) disable iff (!rst_b_i)
		tx_ans_o.late);
	COV_HALF_WRITE: cover property (@(posedge clock_i)
		disable iff (!rst_b_i) wr_set && avs_byteenable_i == 4'hC);
	COV_DONE: cover property (@(posedge clock_i) disable iff (!rst_b_i)
		state_q == MCR_SEND && tx_evt_i.done);

endmodule
`default_nettype wire

// [verification/mcr_mac_model.sv]
// Behavioural transmit side of the MAC that feeds the collision block
`timescale 1ns/1ps
`default_nettype none

module mcr_mac_model (
	input  wire logic                 clock_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 go_i,
	input  wire logic [5:0]           coll_at_i,
	output var  mcr_pkg::mcr_tx_evt_t evt_o,
	output var  logic                 coll_o
);
	import mcr_pkg::*;

	logic [6:0] cnt_q;
	logic       busy_q;

	// Forty-one byte frame, collision raised from the chosen byte on
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
			evt_o  <= '0;
			coll_o <= 1'b0;
		end else begin
			evt_o  <= '0;
			coll_o <= busy_q && coll_at_i != 0 && cnt_q >= 7'(coll_at_i);
			if (go_i) begin
				busy_q          <= 1'b1;
				cnt_q           <= '0;
				evt_o.start     <= 1'b1;
				evt_o.byte_sent <= 1'b1;
			end else if (busy_q) begin
				cnt_q           <= cnt_q + 7'h01;
				evt_o.byte_sent <= cnt_q != 7'h28;
				if (cnt_q == 7'h28) begin
					busy_q     <= 1'b0;
					evt_o.done <= coll_at_i == 0;
				end
			end
		end
	end
endmodule

`default_nettype wire

// [verification/test_mac_collision_retry_config.sv]
// Self-checking bench for the collision window and retry limit block
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.svh"

module test_mac_collision_retry_config;
	import mcr_pkg::*;
	logic        clock_i = 0, rst_b_i = 0, rd = 0, wr = 0, go = 0;
	logic [7:0]  adr = '0;
	logic [3:0]  be = '0;
	logic [31:0] wd = '0, rdq, q;
	logic [5:0]  coll_at = '0;
	logic        coll, irq, wait_o;
	mcr_tx_evt_t evt;
	mcr_tx_ans_t ans, seen;
	int          miscompares = 0, n_tests = 0;

	always #12.5 clock_i = ~clock_i;

	mcr_collision_retry dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_byteenable_i(be), .avs_writedata_i(wd),
		.avs_readdata_o(rdq), .avs_waitrequest_o(wait_o),
		.tx_evt_i(evt), .collision_i(coll), .tx_ans_o(ans), .irq_o(irq));
	mcr_mac_model mac_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
		.go_i(go), .coll_at_i(coll_at), .evt_o(evt), .coll_o(coll));

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [3:0] b, input logic [31:0] d);
		int n = 0;
		@(posedge clock_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		be <= b;
		wd <= d;
		do begin
			@(posedge clock_i);
			n++;
		end while (wait_o !== 1'b0);
		q = rdq;
		rd <= 1'b0;
		wr <= 1'b0;
		chk("wait edges", 2, n);
	endtask

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(0, a, 4'hF, 32'h0);
		chk(nm, e, q);
	endtask

	// One frame; records the first answer pulse
	task automatic frame(input logic [5:0] at);
		@(posedge clock_i);
		coll_at <= at;
		go <= 1'b1;
		@(posedge clock_i);
		go <= 1'b0;
		seen = '0;
		repeat (60) begin
			@(posedge clock_i);
			if (ans !== '0 && seen === '0) seen = ans;
		end
		coll_at <= '0;
	endtask

	task automatic t_reset;
		rchk("cfg", `MCR_OFS_CFG, 32'h0000370F);
		rchk("stat", `MCR_OFS_STAT, 32'h00000000);
		rchk("mask", `MCR_OFS_MASK, 32'h00000000);
	endtask

	task automatic t_access;
		bus(1, `MCR_OFS_CFG, 4'hF, 32'hFFFFFFFF);
		rchk("cfg", `MCR_OFS_CFG, 32'h00003F0F);
		bus(1, `MCR_OFS_CFG, 4'h1, 32'h0);
		rchk("cfg", `MCR_OFS_CFG, 32'h00003F0F);
		bus(1, `MCR_OFS_CFG, 4'hC, 32'h0);
		rchk("cfg", `MCR_OFS_CFG, 32'h00003F0F);
		bus(1, `MCR_OFS_CFG, 4'h3, 32'h0);
		rchk("cfg", `MCR_OFS_CFG, 32'h00000000);
		bus(1, `MCR_OFS_CFG_SET, 4'hF, 32'h00002A05);
		bus(1, `MCR_OFS_CFG_CLR, 4'hF, 32'h00000801);
		bus(1, `MCR_OFS_CFG_INV, 4'h3, 32'h00000FFF);
		rchk("cfg", `MCR_OFS_CFG, 32'h00002D0B);
		bus(1, `MCR_OFS_CFG_SET, 4'h2, 32'h0000FFFF);
		rchk("cfg", `MCR_OFS_CFG, 32'h00002D0B);
		bus(0, `MCR_OFS_CFG, 4'h1, 32'h0);
		chk("byte read", 32'h00000000, q);
		rchk("unmapped", 8'h40, 32'h00000000);
	endtask

	task automatic t_retry;
		bus(1, `MCR_OFS_CFG, 4'hF, 32'h00003F01);
		bus(1, `MCR_OFS_MASK, 4'hF, 32'h00000001);
		frame(6'd3);
		chk("ans", 3'b100, seen);
		chk("irq", 0, irq);
		frame(6'd3);
		chk("ans", 3'b010, seen);
		rchk("stat", `MCR_OFS_STAT, 32'h00000005);
		chk("irq", 1, irq);
		bus(1, `MCR_OFS_STAT, 4'hF, 32'h00000007);
		rchk("stat", `MCR_OFS_STAT, 32'h00000000);
		chk("irq", 0, irq);
	endtask

	task automatic t_late;
		bus(1, `MCR_OFS_CFG, 4'hF, 32'h0000010F);
		frame(6'd20);
		chk("ans", 3'b001, seen);
		bus(1, `MCR_OFS_CFG, 4'hF, 32'h00003F00);
		frame(6'd3);
		chk("ans", 3'b010, seen);
		rchk("stat", `MCR_OFS_STAT, 32'h00000003);
	endtask

	// Clean frame resets the attempt count
	task automatic t_done;
		bus(1, `MCR_OFS_CFG, 4'hF, 32'h00003F01);
		frame(6'd3);
		chk("ans", 3'b100, seen);
		rchk("stat", `MCR_OFS_STAT, 32'h00000107);
		frame(6'd0);
		chk("ans", 3'b000, seen);
		rchk("stat", `MCR_OFS_STAT, 32'h00000007);
		frame(6'd3);
		chk("ans", 3'b100, seen);
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
		t_reset();
		t_access();
		t_retry();
		t_late();
		t_done();
		conclude();
	end

	// Watchdog against a hung handshake
	initial begin
		#(25 * 20000);
		miscompares++;
		conclude();
	end
endmodule

`default_nettype wire
